/* shared/pimf_defs.vh */
// constants for the priority interrupt and memory fault block
// assumes a 250 MHz board basic clock
`ifndef PIMF_DEFS_VH
`define PIMF_DEFS_VH

// register offsets, plain register port
`define PIMF_REG_CUR_LEVEL 3'h0
`define PIMF_REG_DETECT 3'h1
`define PIMF_REG_ENABLE 3'h2
`define PIMF_REG_CTRL 3'h3
`define PIMF_REG_ENCODED 3'h4

// control register command bits
`define PIMF_CTRL_WAIT 0
`define PIMF_CTRL_LVL_CHECK 1
`define PIMF_CTRL_ACK 2

// reset values
`define PIMF_RST_LEVEL 4'h0
`define PIMF_RST_DETECT 16'h0000
`define PIMF_RST_ENABLE 16'h0000

// hardware-served levels 10..15
`define PIMF_HW_LEVEL_MASK 16'hfc00
`define PIMF_LVL_TERM_OUT 10
`define PIMF_LVL_MASS_DMA 11
`define PIMF_LVL_TERM_IN 12
`define PIMF_LVL_RTC 13
`define PIMF_LVL_INTERNAL 14

// positions in the general group, lowest first
`define PIMF_GEN_MAILBOX 0
`define PIMF_GEN_LINK 1
`define PIMF_GEN_SDMA 2
`define PIMF_GEN_ALU_ZERO 3
`define PIMF_GEN_PARITY 4
`define PIMF_GEN_OOR 5
`define PIMF_GEN_POWER 6
// positions in the console group
`define PIMF_CON_STOP 0
`define PIMF_CON_RTC 2
`define PIMF_CON_MCL 7

// internal data bus source select codes
`define PIMF_IDB_GENERAL 5'h01
`define PIMF_IDB_CONSOLE 5'h02
`define PIMF_IDB_FAULT_ADDR 5'h03
`define PIMF_IDB_FAULT_STAT 5'h04

// memory cycle timing
`define PIMF_CLK_NS 4
`define PIMF_TAP_FALL_NS 60
`define PIMF_RDY_RISE_NS 135
`define PIMF_TAP_RISE_NS 195
`define PIMF_RDY_FALL_NS 225
`define PIMF_TAP_FALL_CYC ((`PIMF_TAP_FALL_NS + `PIMF_CLK_NS - 1) / `PIMF_CLK_NS)
`define PIMF_RDY_RISE_CYC ((`PIMF_RDY_RISE_NS + `PIMF_CLK_NS - 1) / `PIMF_CLK_NS)
`define PIMF_TAP_RISE_CYC ((`PIMF_TAP_RISE_NS + `PIMF_CLK_NS - 1) / `PIMF_CLK_NS)
`define PIMF_RDY_FALL_CYC (`PIMF_RDY_FALL_NS / `PIMF_CLK_NS)

`endif

/* rtl/pimf_prienc.v */
// highest-set-bit priority encoder, 16 inputs
// combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none

module pimf_prienc (
  // request vector, bit 15 highest
  input wire [15:0] i_req,
  // result
  output reg o_valid,
  output reg [3:0] o_code
);
  integer k;

  always @* begin
    o_valid = 1'b0;
    o_code = 4'h0;
    for (k = 0; k < 16; k = k + 1) begin
      if (i_req[k]) begin
        o_valid = 1'b1;
        o_code = k[3:0];
      end
    end
  end
endmodule

`default_nettype wire

/* rtl/pimf_parity.v */
// even parity generation and check for one 16-bit dram word
// combinational; check bits stored as the ninth bit of each byte
`timescale 1ns/1ps
`default_nettype none

module pimf_parity (
  // data and stored check bits
  input wire [15:0] i_data,
  input wire i_chk_upper,
  input wire i_chk_lower,
  // generated bits and check result
  output wire o_gen_upper,
  output wire o_gen_lower,
  output wire o_fail
);
  // even: byte plus its bit holds an even count of ones
  assign o_gen_upper = ^i_data[15:8];
  assign o_gen_lower = ^i_data[7:0];
  assign o_fail = (^{i_data[15:8], i_chk_upper}) | (^{i_data[7:0], i_chk_lower});
endmodule

`default_nettype wire

/* rtl/pimf_top.v */
// priority interrupt logic with dram parity and out-of-map detection
// assumes sources arrive from pins, memory controls from same-clock logic
//
// Contract
// - current level always 0 to 15
// - fixed levels 10,11,12,13 and 14
// - hardware serves only levels ten to fifteen
// - current level held in own register
// - enabled detect bits feed priority encoder
// - change level only when encoded exceeds current; code also loads it on a level register write and sets it to 0 on wait
// - wait clears detect bit of level left
// - group sources ranked by position, last highest
// - console +0 stop when halted, +2 clock
// - active source raises general or console request
// - console request qualified unless console stopped
// - general or qualified console request sets pending flip-flop
// - qualified request and pending drive trap vector
// - source select returns group highest source code
// - write stores even parity bit per byte
// - read check flags any byte mismatch
// - cpu read fault raises source, captures address
// - host read fault sets channel check at tap
// - host channel check cleared by next write
// - out-of-map latched at tap fall, flagged next
// - out-of-map latch cleared at cycle end strobe
// - end strobe high from 135 to 225ns
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pimf_defs.vh"

module pimf_top #(
  parameter [15:0] MAP_TOP = 16'hc000,
  parameter [11:0] GEN_VEC_BASE = 12'h100,
  parameter [11:0] CON_VEC_BASE = 12'h140
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_nrst,
  // register port
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // microcode source select
  input wire [4:0] i_idb_source_sel,
  output reg [15:0] o_idb_data,
  // interrupt source pins
  input wire i_run,
  input wire i_console_stopped,
  input wire i_rtc_tick,
  input wire i_master_clear_switch,
  input wire i_host_to_cpu_mailbox_req,
  input wire i_serial_link_req,
  input wire i_serial_dma_req,
  input wire i_alu_zero_fault_source,
  input wire i_power_fail,
  input wire i_term_out_req,
  input wire i_mass_dma_req,
  input wire i_term_in_req,
  // memory cycle controls
  input wire i_cycle_start,
  input wire i_cycle_write,
  input wire i_cycle_host,
  input wire i_cycle_refresh,
  input wire [15:0] i_mem_addr,
  input wire [15:0] i_mem_wdata,
  input wire [15:0] i_mem_rdata,
  input wire i_stored_check_bit_upper,
  input wire i_stored_check_bit_lower,
  input wire i_read_data_ready,
  input wire i_host_memw,
  // memory outputs
  output reg o_gen_check_bit_upper,
  output reg o_gen_check_bit_lower,
  output reg o_cycle_tap_60ns,
  output reg o_cycle_end_strobe,
  output reg o_memory_out_of_range,
  output reg o_iochchk,
  output reg o_capture_fault_address_strobe,
  output reg o_capture_fault_status_strobe,
  // interrupt outputs
  output reg [3:0] o_current_level_reg,
  output reg [3:0] o_encoded_level_code,
  output reg o_qualified_console_request,
  output reg o_pending_interrupt_ff,
  output reg [11:0] o_trap_vector
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  wire [11:0] pins_raw;
  reg [11:0] pins_s1_q;
  reg [11:0] pins_q;

  assign pins_raw = {i_term_in_req, i_mass_dma_req, i_term_out_req,
                     i_power_fail, i_alu_zero_fault_source,
                     i_serial_dma_req, i_serial_link_req,
                     i_host_to_cpu_mailbox_req, i_master_clear_switch,
                     i_rtc_tick, i_console_stopped, i_run};

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pins_s1_q <= 12'h000;
      pins_q <= 12'h000;
    end else begin
      pins_s1_q <= pins_raw;
      pins_q <= pins_s1_q;
    end
  end

  wire run_s = pins_q[0];
  wire con_stop_s = pins_q[1];
  wire rtc_s = pins_q[2];
  wire mcl_s = pins_q[3];
  wire mbox_s = pins_q[4];
  wire link_s = pins_q[5];
  wire sdma_s = pins_q[6];
  wire alu_s = pins_q[7];
  wire pow_s = pins_q[8];
  wire tout_s = pins_q[9];
  wire mdma_s = pins_q[10];
  wire tin_s = pins_q[11];

  // ==========================================================
  // memory cycle timing
  // ==========================================================
  reg [5:0] cyc_cnt_q;
  reg cyc_act_q;
  reg cyc_wr_q;
  reg cyc_host_q;
  reg cyc_ref_q;
  reg [15:0] cyc_addr_q;
  wire at_tap_fall = cyc_act_q && (cyc_cnt_q == `PIMF_TAP_FALL_CYC);
  wire at_rdy_rise = cyc_act_q && (cyc_cnt_q == `PIMF_RDY_RISE_CYC);
  wire at_tap_rise = cyc_act_q && (cyc_cnt_q == `PIMF_TAP_RISE_CYC);
  wire at_rdy_fall = cyc_act_q && (cyc_cnt_q == `PIMF_RDY_FALL_CYC);

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_cnt_q <= 6'h00;
      cyc_act_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      cyc_host_q <= 1'b0;
      cyc_ref_q <= 1'b0;
      cyc_addr_q <= 16'h0000;
      o_cycle_tap_60ns <= 1'b1;
      o_cycle_end_strobe <= 1'b0;
    end else begin
      if (i_cycle_start && !cyc_act_q) begin
        cyc_act_q <= 1'b1;
        cyc_cnt_q <= 6'h00;
        cyc_wr_q <= i_cycle_write;
        cyc_host_q <= i_cycle_host;
        cyc_ref_q <= i_cycle_refresh;
        cyc_addr_q <= i_mem_addr;
      end else if (cyc_act_q) begin
        cyc_cnt_q <= cyc_cnt_q + 6'h01;
        if (at_rdy_fall)
          cyc_act_q <= 1'b0;
      end
      if (at_tap_fall)
        o_cycle_tap_60ns <= 1'b0;
      else if (at_tap_rise)
        o_cycle_tap_60ns <= 1'b1;
      if (at_rdy_rise)
        o_cycle_end_strobe <= 1'b1;
      else if (at_rdy_fall)
        o_cycle_end_strobe <= 1'b0;
    end
  end

  // ==========================================================
  // parity generation and check
  // ==========================================================
  wire gen_up;
  wire gen_lo;
  wire chk_fail;

  pimf_parity u_parity_wr (
    .i_data(i_mem_wdata),
    .i_chk_upper(1'b0),
    .i_chk_lower(1'b0),
    .o_gen_upper(gen_up),
    .o_gen_lower(gen_lo),
    .o_fail()
  );

  pimf_parity u_parity_rd (
    .i_data(i_mem_rdata),
    .i_chk_upper(i_stored_check_bit_upper),
    .i_chk_lower(i_stored_check_bit_lower),
    .o_gen_upper(),
    .o_gen_lower(),
    .o_fail(chk_fail)
  );

  wire up_fail = ^{i_mem_rdata[15:8], i_stored_check_bit_upper};
  wire lo_fail = ^{i_mem_rdata[7:0], i_stored_check_bit_lower};
  wire host_rd = cyc_act_q && cyc_host_q && !cyc_wr_q;
  wire cpu_fault_ev = i_read_data_ready && !cyc_host_q && chk_fail;

  reg cpu_parity_fault_q;
  reg host_parity_fault_q;
  reg address_not_mapped_q;
  reg oor_src_q;
  reg capt_lock_q;
  reg [15:0] fault_addr_q;
  reg [3:0] fault_stat_q;
  wire addr_read = (i_idb_source_sel == `PIMF_IDB_FAULT_ADDR);
  wire oor_ev = address_not_mapped_q && !o_memory_out_of_range;
  wire capture = (cpu_fault_ev || (oor_ev && !cyc_ref_q)) && !capt_lock_q;

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gen_check_bit_upper <= 1'b0;
      o_gen_check_bit_lower <= 1'b0;
      cpu_parity_fault_q <= 1'b0;
      host_parity_fault_q <= 1'b0;
      o_iochchk <= 1'b0;
      address_not_mapped_q <= 1'b0;
      o_memory_out_of_range <= 1'b0;
      oor_src_q <= 1'b0;
      capt_lock_q <= 1'b0;
      fault_addr_q <= 16'h0000;
      fault_stat_q <= 4'h0;
      o_capture_fault_address_strobe <= 1'b0;
      o_capture_fault_status_strobe <= 1'b0;
    end else begin
      if (i_cycle_start && i_cycle_write) begin
        o_gen_check_bit_upper <= gen_up;
        o_gen_check_bit_lower <= gen_lo;
      end
      // cpu fault source; event wins over the unlocking read
      if (cpu_fault_ev)
        cpu_parity_fault_q <= 1'b1;
      else if (addr_read)
        cpu_parity_fault_q <= 1'b0;
      o_capture_fault_address_strobe <= capture;
      o_capture_fault_status_strobe <= capture;
      if (capture) begin
        fault_addr_q <= cyc_addr_q;
        fault_stat_q <= {cpu_fault_ev, !cpu_fault_ev,
                         up_fail & cpu_fault_ev, lo_fail & cpu_fault_ev};
      end
      // held until the fault address is read
      if (capture)
        capt_lock_q <= 1'b1;
      else if (addr_read)
        capt_lock_q <= 1'b0;
      // host read: flag then report at the tap return
      if (host_rd && chk_fail)
        host_parity_fault_q <= 1'b1;
      else if (i_cycle_start && !cyc_act_q)
        host_parity_fault_q <= 1'b0;
      if (at_tap_rise && host_parity_fault_q)
        o_iochchk <= 1'b1;
      else if (i_host_memw)
        o_iochchk <= 1'b0;
      // out-of-map detection
      if (at_tap_fall && (cyc_addr_q >= MAP_TOP))
        address_not_mapped_q <= 1'b1;
      else if (at_rdy_rise)
        address_not_mapped_q <= 1'b0;
      o_memory_out_of_range <= address_not_mapped_q;
      if (oor_ev && !cyc_ref_q)
        oor_src_q <= 1'b1;
      else if (addr_read)
        oor_src_q <= 1'b0;
    end
  end

  // ==========================================================
  // vector groups
  // ==========================================================
  wire [15:0] gen_vec;
  wire [15:0] con_vec;
  wire gen_any;
  wire con_any;
  wire [3:0] gen_code;
  wire [3:0] con_code;

  assign gen_vec = {9'h000, pow_s, oor_src_q, cpu_parity_fault_q,
                    alu_s, sdma_s, link_s, mbox_s};
  assign con_vec = {8'h00, mcl_s, 4'h0, rtc_s, 1'b0, !run_s};

  pimf_prienc u_gen_enc (
    .i_req(gen_vec),
    .o_valid(gen_any),
    .o_code(gen_code)
  );

  pimf_prienc u_con_enc (
    .i_req(con_vec),
    .o_valid(con_any),
    .o_code(con_code)
  );

  // ==========================================================
  // program levels
  // ==========================================================
  reg [15:0] level_detect_bits_q;
  reg [15:0] level_enable_bits_q;
  reg [15:0] det_set;
  wire lvl_any;
  wire [3:0] lvl_code;
  wire internal_any = alu_s | pow_s | cpu_parity_fault_q | oor_src_q;
  wire ctrl_wr = i_wr && (i_addr == `PIMF_REG_CTRL);
  wire do_wait = ctrl_wr && i_wdata[`PIMF_CTRL_WAIT];
  wire do_check = ctrl_wr && i_wdata[`PIMF_CTRL_LVL_CHECK];
  wire do_ack = ctrl_wr && i_wdata[`PIMF_CTRL_ACK];

  always @* begin
    det_set = 16'h0000;
    det_set[`PIMF_LVL_TERM_OUT] = tout_s;
    det_set[`PIMF_LVL_MASS_DMA] = mdma_s;
    det_set[`PIMF_LVL_TERM_IN] = tin_s;
    det_set[`PIMF_LVL_RTC] = rtc_s;
    det_set[`PIMF_LVL_INTERNAL] = internal_any;
  end

  pimf_prienc u_lvl_enc (
    .i_req(level_detect_bits_q & level_enable_bits_q & `PIMF_HW_LEVEL_MASK),
    .o_valid(lvl_any),
    .o_code(lvl_code)
  );

  integer b;

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      level_detect_bits_q <= `PIMF_RST_DETECT;
      level_enable_bits_q <= `PIMF_RST_ENABLE;
      o_current_level_reg <= `PIMF_RST_LEVEL;
    end else begin
      if (i_wr && (i_addr == `PIMF_REG_ENABLE))
        level_enable_bits_q <= i_wdata;
      // source set wins over wait or software clear
      for (b = 0; b < 16; b = b + 1) begin
        if (det_set[b])
          level_detect_bits_q[b] <= 1'b1;
        else if (i_wr && (i_addr == `PIMF_REG_DETECT))
          level_detect_bits_q[b] <= i_wdata[b];
        else if (do_wait && (o_current_level_reg == b[3:0]))
          level_detect_bits_q[b] <= 1'b0;
      end
      // 4-bit register keeps the level within 0..15
      if (i_wr && (i_addr == `PIMF_REG_CUR_LEVEL))
        o_current_level_reg <= i_wdata[3:0];
      else if (do_check && lvl_any && (lvl_code > o_current_level_reg))
        o_current_level_reg <= lvl_code;
      else if (do_wait)
        o_current_level_reg <= `PIMF_RST_LEVEL;
      o_encoded_level_code <= lvl_any ? lvl_code : 4'h0;
    end
  end

  // ==========================================================
  // request, pending and trap vector
  // ==========================================================
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_qualified_console_request <= 1'b0;
      o_pending_interrupt_ff <= 1'b0;
      o_trap_vector <= 12'h000;
    end else begin
      o_qualified_console_request <= con_any && !con_stop_s;
      if (gen_any || (con_any && !con_stop_s))
        o_pending_interrupt_ff <= 1'b1;
      else if (do_ack)
        o_pending_interrupt_ff <= 1'b0;
      if (o_qualified_console_request)
        o_trap_vector <= CON_VEC_BASE;
      else if (o_pending_interrupt_ff)
        o_trap_vector <= GEN_VEC_BASE;
      else
        o_trap_vector <= 12'h000;
    end
  end

  // ==========================================================
  // internal data bus and register reads
  // ==========================================================
  wire [15:0] ctrl_stat = {10'h000, o_pending_interrupt_ff,
                           o_qualified_console_request, gen_any,
                           con_any, lvl_any, 1'b0};

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_idb_data <= 16'h0000;
      o_rdata <= 16'h0000;
    end else begin
      case (i_idb_source_sel)
        `PIMF_IDB_GENERAL: o_idb_data <= {12'h000, gen_code};
        `PIMF_IDB_CONSOLE: o_idb_data <= {12'h000, con_code};
        `PIMF_IDB_FAULT_ADDR: o_idb_data <= fault_addr_q;
        `PIMF_IDB_FAULT_STAT: o_idb_data <= {12'h000, fault_stat_q};
        default: o_idb_data <= 16'h0000;
      endcase
      if (i_rd) begin
        case (i_addr)
          `PIMF_REG_CUR_LEVEL: o_rdata <= {12'h000, o_current_level_reg};
          `PIMF_REG_DETECT: o_rdata <= level_detect_bits_q;
          `PIMF_REG_ENABLE: o_rdata <= level_enable_bits_q;
          `PIMF_REG_CTRL: o_rdata <= ctrl_stat;
          `PIMF_REG_ENCODED: o_rdata <= {11'h000, lvl_any, lvl_code};
          default: o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end
endmodule

`default_nettype wire

/* tb/pimf_top_props.sv */
// checker for the interrupt and memory fault block ports
// assumes binding onto pimf_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pimf_props #(
  parameter [11:0] GEN_VEC_BASE = 12'h100,
  parameter [11:0] CON_VEC_BASE = 12'h140
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // memory inputs
  input wire logic i_cycle_start,
  input wire logic i_cycle_write,
  input wire logic [15:0] i_mem_wdata,
  input wire logic i_read_data_ready,
  input wire logic i_host_memw,
  // watched outputs
  input wire logic o_gen_check_bit_upper,
  input wire logic o_gen_check_bit_lower,
  input wire logic o_cycle_tap_60ns,
  input wire logic o_cycle_end_strobe,
  input wire logic o_memory_out_of_range,
  input wire logic o_iochchk,
  input wire logic o_capture_fault_address_strobe,
  input wire logic o_capture_fault_status_strobe,
  input wire logic [3:0] o_encoded_level_code,
  input wire logic o_qualified_console_request,
  input wire logic o_pending_interrupt_ff,
  input wire logic [11:0] o_trap_vector
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // ==========
  // properties
  property p_hw_levels;
    o_encoded_level_code == 4'h0 || o_encoded_level_code >= 4'ha;
  endproperty
  a_hw_levels: assert property (p_hw_levels) else $error("encoded level below ten");
  property p_pend_follow;
    $rose(o_qualified_console_request) |-> ##[0:1] o_pending_interrupt_ff;
  endproperty
  a_pend_follow: assert property (p_pend_follow) else $error("pending not set by console");
  property p_trap_vec;
    o_trap_vector == ($past(o_qualified_console_request) ? CON_VEC_BASE :
      ($past(o_pending_interrupt_ff) ? GEN_VEC_BASE : 12'h000));
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
  property p_strobe_len;
    $rose(o_cycle_end_strobe) |-> o_cycle_end_strobe[*8] ##[14:16] !o_cycle_end_strobe;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("end strobe width wrong");
  property p_strobe_tap;
    $rose(o_cycle_end_strobe) |-> !o_cycle_tap_60ns;
  endproperty
  a_strobe_tap: assert property (p_strobe_tap) else $error("end strobe outside tap low");
  property p_chk_at_tap;
    $rose(o_iochchk) |-> $past(o_cycle_tap_60ns, 2) == 1'b0;
  endproperty
  a_chk_at_tap: assert property (p_chk_at_tap) else $error("host check raised off tap");
  property p_chk_clear;
    i_host_memw && o_cycle_tap_60ns && $past(o_cycle_tap_60ns) |=> !o_iochchk;
  endproperty
  a_chk_clear: assert property (p_chk_clear) else $error("host check not cleared");
  property p_oor_rise;
    $rose(o_memory_out_of_range) |-> !o_cycle_tap_60ns;
  endproperty
  a_oor_rise: assert property (p_oor_rise) else $error("out of range before tap fall");
  property p_oor_clear;
    $rose(o_cycle_end_strobe) |-> ##[1:3] !o_memory_out_of_range;
  endproperty
  a_oor_clear: assert property (p_oor_clear) else $error("out of range not cleared");
  property p_capture;
    o_capture_fault_address_strobe |-> o_capture_fault_status_strobe &&
      ($past(i_read_data_ready) || $rose(o_memory_out_of_range));
  endproperty
  a_capture: assert property (p_capture) else $error("capture strobe without ready");
  property p_gen_bits;
    i_cycle_start && i_cycle_write && o_cycle_tap_60ns && !o_cycle_end_strobe |-> ##2
      (o_gen_check_bit_upper == ^$past(i_mem_wdata[15:8], 2)) &&
      (o_gen_check_bit_lower == ^$past(i_mem_wdata[7:0], 2));
  endproperty
  a_gen_bits: assert property (p_gen_bits) else $error("generated check bit wrong");
endmodule
`default_nettype wire

/* tb/pimf_periph.sv */
// peripheral request source on the far side of the block
// assumes the block clock and active low async reset
`timescale 1ns/1ps
`default_nettype none
module pimf_periph (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // device event and driver transfer
  input wire logic i_event,
  input wire logic i_io_transfer,
  // request to the block
  output logic o_req
);
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_req <= 1'b0;
    end else if (i_io_transfer) begin
      o_req <= 1'b0;
    end else if (i_event) begin
      o_req <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/test_priority_interrupt_and_memory_fault.sv */
// self-checking bench for the interrupt and memory fault block
// assumes pimf_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pimf_defs.vh"
module test_priority_interrupt_and_memory_fault;
  localparam [11:0] GENV = 12'h100;
  localparam [11:0] CONV = 12'h140;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_run = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [4:0] i_idb_source_sel = 5'h00;
  logic [15:0] i_wdata = 16'h0000, i_mem_addr = 16'h0000, i_mem_wdata = 16'h0000, i_mem_rdata = 16'hffff;
  logic [3:0] src = 4'h0;
  logic i_console_stopped = 1'b0, i_master_clear_switch = 1'b0, i_host_to_cpu_mailbox_req = 1'b0;
  logic i_serial_link_req = 1'b0, i_alu_zero_fault_source = 1'b0, ev = 1'b0, io_transfer_instruction = 1'b0;
  logic i_cycle_start = 1'b0, i_cycle_write = 1'b0, i_cycle_host = 1'b0, i_read_data_ready = 1'b0;
  logic i_stored_check_bit_upper = 1'b0, i_stored_check_bit_lower = 1'b0, i_host_memw = 1'b0;
  logic cap_seen = 1'b0, oor_seen = 1'b0;
  wire [15:0] o_rdata, o_idb_data;
  wire [3:0] o_current_level_reg, o_encoded_level_code;
  wire [11:0] o_trap_vector;
  wire o_gen_check_bit_upper, o_gen_check_bit_lower, o_cycle_tap_60ns, o_cycle_end_strobe, dma_req;
  wire o_memory_out_of_range, o_iochchk, o_capture_fault_address_strobe, o_capture_fault_status_strobe;
  wire o_qualified_console_request, o_pending_interrupt_ff;
  integer n_mismatch = 0, checks = 0, cyc = 0;
  int lv [4] = '{`PIMF_LVL_TERM_OUT, `PIMF_LVL_MASS_DMA, `PIMF_LVL_TERM_IN, `PIMF_LVL_RTC};
  pimf_top #(.MAP_TOP(16'hc000), .GEN_VEC_BASE(GENV), .CON_VEC_BASE(CONV)) dut (.*, .i_rtc_tick(src[3]),
    .i_serial_dma_req(dma_req), .i_power_fail(1'b0), .i_term_out_req(src[0]), .i_mass_dma_req(src[1]),
    .i_term_in_req(src[2]), .i_cycle_refresh(1'b0));
  pimf_periph u_dma (.i_ref_clk, .i_nrst, .i_event(ev), .i_io_transfer(io_transfer_instruction), .o_req(dma_req));
  always #2 i_ref_clk = ~i_ref_clk;
  // ==========
  // shared tasks
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_capture_fault_address_strobe) cap_seen <= 1'b1;
    if (o_memory_out_of_range) oor_seen <= 1'b1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic idb(input logic [4:0] s, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_idb_source_sel <= s;
    tick(2);
    #1 chk(o_idb_data, exp);
    @(posedge i_ref_clk);
    i_idb_source_sel <= 5'h00;
  endtask
  task automatic mcyc(input logic w, h, input logic [15:0] a, d, input logic up, lo);
    @(posedge i_ref_clk);
    i_cycle_start <= 1'b1;
    i_cycle_write <= w;
    i_cycle_host <= h;
    i_mem_addr <= a;
    i_mem_wdata <= d;
    i_mem_rdata <= d;
    i_stored_check_bit_upper <= up;
    i_stored_check_bit_lower <= lo;
    @(posedge i_ref_clk);
    i_cycle_start <= 1'b0;
    tick(30);
    i_read_data_ready <= !w && !h;
    @(posedge i_ref_clk);
    i_read_data_ready <= 1'b0;
    tick(30);
    i_mem_rdata <= ~d;
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    rd(0, 16'h0000);
    rd(1, 16'h0000);
    rd(2, 16'h0000);
    wr(0, 16'h0007);
    wr(6, 16'hffff);
    rd(0, 16'h0007);
    rd(6, 16'h0000);
    wr(0, 16'h0000);
    #1 chk(o_cycle_tap_60ns, 16'h0001);
    $display("test regs done");
  endtask
  task automatic t_levels;
    wr(2, 16'hfc00);
    for (int i = 0; i < 4; i++) begin
      src <= 4'(1 << i);
      tick(5);
      rd(4, 16'h0010 + 16'(lv[i]));
      src <= 4'h0;
      tick(4);
      wr(1, 16'h0000);
    end
    src <= 4'h5;
    tick(5);
    wr(3, 16'h0002);
    rd(0, 16'h000c);
    src <= 4'h0;
    tick(4);
    wr(3, 16'h0001);
    rd(1, 16'h0400);
    wr(0, 16'h000b);
    wr(3, 16'h0002);
    rd(0, 16'h000b);
    wr(1, 16'h0000);
    wr(0, 16'h0000);
    $display("test levels done");
  endtask
  task automatic t_console;
    i_run <= 1'b0;
    src <= 4'h8;
    tick(5);
    idb(`PIMF_IDB_CONSOLE, 16'h0002);
    i_master_clear_switch <= 1'b1;
    tick(5);
    idb(`PIMF_IDB_CONSOLE, 16'h0007);
    #1 chk(o_qualified_console_request, 16'h0001);
    chk(o_pending_interrupt_ff, 16'h0001);
    chk(o_trap_vector, CONV);
    @(posedge i_ref_clk);
    i_console_stopped <= 1'b1;
    tick(3);
    wr(3, 16'h0004);
    tick(5);
    #1 chk(o_qualified_console_request, 16'h0000);
    chk(o_pending_interrupt_ff, 16'h0000);
    @(posedge i_ref_clk);
    i_run <= 1'b1;
    src <= 4'h0;
    i_master_clear_switch <= 1'b0;
    i_console_stopped <= 1'b0;
    tick(5);
    $display("test console done");
  endtask
  task automatic t_general;
    i_host_to_cpu_mailbox_req <= 1'b1;
    i_serial_link_req <= 1'b1;
    tick(5);
    idb(`PIMF_IDB_GENERAL, 16'h0001);
    #1 chk(o_pending_interrupt_ff, 16'h0001);
    chk(o_trap_vector, GENV);
    @(posedge i_ref_clk);
    ev <= 1'b1;
    @(posedge i_ref_clk);
    ev <= 1'b0;
    tick(5);
    idb(`PIMF_IDB_GENERAL, 16'h0002);
    i_alu_zero_fault_source <= 1'b1;
    tick(5);
    idb(`PIMF_IDB_GENERAL, 16'h0003);
    rd(4, 16'h001e);
    io_transfer_instruction <= 1'b1;
    i_alu_zero_fault_source <= 1'b0;
    i_host_to_cpu_mailbox_req <= 1'b0;
    i_serial_link_req <= 1'b0;
    @(posedge i_ref_clk);
    io_transfer_instruction <= 1'b0;
    tick(5);
    wr(1, 16'h0000);
    wr(3, 16'h0004);
    $display("test general done");
  endtask
  task automatic t_memory;
    mcyc(1'b1, 1'b0, 16'h0100, 16'h0307, 1'b0, 1'b0);
    #1 chk({o_gen_check_bit_upper, o_gen_check_bit_lower}, 16'h0001);
    mcyc(1'b0, 1'b0, 16'h0300, 16'h00ff, 1'b0, 1'b0);
    #1 chk(cap_seen, 16'h0000);
    mcyc(1'b0, 1'b0, 16'h0200, 16'h00ff, 1'b0, 1'b1);
    #1 chk(cap_seen, 16'h0001);
    idb(`PIMF_IDB_FAULT_STAT, 16'h0009);
    idb(`PIMF_IDB_FAULT_ADDR, 16'h0200);
    mcyc(1'b0, 1'b1, 16'h0200, 16'h0100, 1'b0, 1'b0);
    #1 chk(o_iochchk, 16'h0001);
    @(posedge i_ref_clk);
    i_host_memw <= 1'b1;
    @(posedge i_ref_clk);
    i_host_memw <= 1'b0;
    tick(1);
    #1 chk(o_iochchk, 16'h0000);
    mcyc(1'b0, 1'b0, 16'hc000, 16'h0000, 1'b0, 1'b0);
    #1 chk(oor_seen, 16'h0001);
    chk(o_memory_out_of_range, 16'h0000);
    idb(`PIMF_IDB_GENERAL, 16'h0005);
    rd(4, 16'h001e);
    $display("test memory done");
  endtask
  initial begin
    tick(16);
    i_nrst <= 1'b1;
    t_regs;
    t_levels;
    t_console;
    t_general;
    t_memory;
    print_verdict;
  end
endmodule
bind pimf_top pimf_props #(.GEN_VEC_BASE(GEN_VEC_BASE), .CON_VEC_BASE(CON_VEC_BASE)) u_props (.*);
`default_nettype wire
